// *** rtl/spr_pkg.sv ***
package spr_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_SLEEP_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_POWER_REDUCTION = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    // sleep_control fields
    localparam int NAP_ARM_BIT = 5;
    localparam int NAP_KIND_LSB = 3;
    localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h38;
    localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] POWER_REDUCTION_RESET = 8'h00;
    // power_reduction fields
    localparam int TWO_WIRE_GATE_BIT = 7;
    localparam int UART1_GATE_BIT = 6;
    localparam int UART0_GATE_BIT = 5;
    localparam int SYNC_SERIAL_GATE_BIT = 4;
    localparam int COUNTER2_GATE_BIT = 3;
    localparam int COUNTER1_GATE_BIT = 2;
    localparam int COUNTER0_GATE_BIT = 1;
    localparam int CONVERTER_GATE_BIT = 0;
    // sleep modes
    localparam logic [1:0] NAP_IDLE = 2'h0;
    localparam logic [1:0] NAP_NOISE = 2'h1;
    localparam logic [1:0] NAP_POWER_DOWN = 2'h2;
    localparam logic [1:0] NAP_STANDBY = 2'h3;
    // monitor fuse codes
    localparam logic [1:0] MON_RESERVED = 2'h0;
    localparam logic [1:0] MON_SAMPLED = 2'h1;
    localparam logic [1:0] MON_ENABLED = 2'h2;
    localparam logic [1:0] MON_DISABLED = 2'h3;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int WAKE_HALT_CYCLES = 4;
    localparam int STANDBY_WAKE_CYCLES = 6;
    localparam int STARTUP_DELAY_US = 64;
    localparam int STARTUP_DELAY_CYCLES = STARTUP_DELAY_US * CLK_MHZ;
    localparam int DETECT_TIME_NS = 2000;
    localparam int DETECT_CYCLES = (DETECT_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SAMPLE_HZ = 1000;
    localparam int SAMPLE_CYCLES = CLK_MHZ * 1000000 / SAMPLE_HZ;
    localparam int WDOG_PULSE_CYCLES = 2;
    localparam int CNT_W = 24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic two_wire;
        logic uart1;
        logic uart0;
        logic sync_serial;
        logic counter2;
        logic counter1;
        logic counter0;
        logic converter;
    } spr_gates_t;

    typedef struct packed {
        logic clk_cpu;
        logic clk_io;
        logic clk_conv;
        logic oscillator;
    } spr_clk_run_t;
endpackage

// *** rtl/spr_sleep_power_reset_control.sv ***
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module spr_sleep_power_reset_control
    import spr_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_DELAY_CYCLES,
    parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
)(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core
    input wire logic sleep_exec,
    input wire logic wake_irq,
    output logic core_halt,
    output logic core_restart,
    // reset sources
    input wire logic power_ok,
    input wire logic reset_pin_n,
    input wire logic reset_pin_enable,
    input wire logic wdog_expire,
    input wire logic wdog_enable,
    input wire logic undervoltage,
    input wire logic [1:0] brownout_active_mode_fuse,
    input wire logic [1:0] brownout_sleep_mode_fuse,
    // outputs to the chip
    output logic port_reset,
    output logic internal_reset,
    output logic monitor_power,
    output spr_gates_t gate_stop,
    output spr_clk_run_t clk_run,
    output logic input_buffer_enable,
    output logic comparator_enable
);

////////////////////////////////////////////////////////////////////////////////

typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE = 4'h4,
    ST_HALT = 4'h8
} spr_state_t;

logic [7:0] sleep_control;
logic [7:0] power_reduction;
spr_state_t state;
logic [1:0] sleep_kind;
logic [3:0] wake_cnt;
logic [CNT_W-1:0] delay_cnt;
logic [CNT_W-1:0] sample_cnt;
logic [7:0] detect_cnt;
logic [2:0] wdog_cnt;
logic wdog_pulse;
logic brownout;
logic forced_continuous;
logic [1:0] fuse_mode;
logic [1:0] mon_mode;
logic mon_on;
logic sample_edge;
logic async_src;
logic aw_held;
logic w_held;
logic [3:0] aw_addr;
logic [31:0] w_data;
logic [3:0] w_strb;

////////////////////////////////////////////////////////////////////////////////
// reset combination

// pin and power-on act without clock
assign async_src = ~power_ok | (reset_pin_enable & ~reset_pin_n);
assign port_reset = async_src | internal_reset;

// watchdog short pulse
always_ff @(posedge aclk)
begin
    if (!power_ok || !aresetn)
    begin
        wdog_pulse <= 1'b0;
        wdog_cnt <= 3'h0;
    end
    else if (wdog_enable && wdog_expire && !wdog_pulse && !internal_reset)
    begin
        wdog_pulse <= 1'b1;
        wdog_cnt <= 3'(WDOG_PULSE_CYCLES - 1);
    end
    else if (wdog_pulse && wdog_cnt != 3'h0)
        wdog_cnt <= wdog_cnt - 3'h1;
    else
        wdog_pulse <= 1'b0;
end

// delay counter, restarted while any source is active
always_ff @(posedge aclk)
begin
    if (!aresetn || async_src || wdog_pulse || brownout)
        delay_cnt <= CNT_W'(STARTUP_CYCLES);
    else if (delay_cnt != '0)
        delay_cnt <= delay_cnt - CNT_W'(1);
end

// power-on drops reset in at once, release waits for the delay
assign internal_reset = ~power_ok | (delay_cnt != '0) | async_src;
assign core_restart = internal_reset;

////////////////////////////////////////////////////////////////////////////////
// brown-out monitor

assign fuse_mode = (state == ST_SLEEP && sleep_kind != NAP_IDLE) ?
    brownout_sleep_mode_fuse : brownout_active_mode_fuse;

assign mon_mode = (forced_continuous || fuse_mode == MON_RESERVED) ?
    MON_ENABLED : fuse_mode;

// 1kHz sample strobe
always_ff @(posedge aclk)
begin
    if (!aresetn || sample_cnt == CNT_W'(SAMPLE_PERIOD - 1))
        sample_cnt <= '0;
    else
        sample_cnt <= sample_cnt + CNT_W'(1);
end
assign sample_edge = (sample_cnt == CNT_W'(SAMPLE_PERIOD - 1));

assign mon_on = (mon_mode == MON_ENABLED) ||
    (mon_mode == MON_SAMPLED && sample_edge);
assign monitor_power = mon_on;

always_ff @(posedge aclk)
begin
    if (!power_ok || !aresetn)
    begin
        detect_cnt <= 8'h00;
        brownout <= 1'b0;
        forced_continuous <= 1'b0;
    end
    else
    begin
        if (mon_mode == MON_SAMPLED && sample_edge && undervoltage)
            forced_continuous <= 1'b1;
        else if (!internal_reset && !undervoltage && !brownout)
            forced_continuous <= 1'b0;
        if (mon_mode == MON_DISABLED || !undervoltage)
        begin
            detect_cnt <= 8'h00;
            brownout <= 1'b0;
        end
        else if (mon_on && detect_cnt >= 8'(DETECT_CYCLES - 1))
            brownout <= 1'b1;
        else if (mon_on)
            detect_cnt <= detect_cnt + 8'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sleep control

always_ff @(posedge aclk)
begin
    if (!aresetn || internal_reset)
    begin
        state <= ST_RUN;
        sleep_kind <= NAP_IDLE;
        wake_cnt <= 4'h0;
    end
    else
    begin
        case (state)
            ST_RUN:
            begin
                if (sleep_exec && sleep_control[NAP_ARM_BIT])
                begin
                    state <= ST_SLEEP;
                    sleep_kind <= sleep_control[NAP_KIND_LSB +: 2];
                end
            end
            ST_SLEEP:
            begin
                if (wake_irq)
                begin
                    state <= ST_WAKE;
                    wake_cnt <= (sleep_kind == NAP_STANDBY) ?
                        4'(STANDBY_WAKE_CYCLES - 1) : 4'h0;
                end
            end
            ST_WAKE:
            begin
                if (wake_cnt == 4'h0)
                begin
                    state <= ST_HALT;
                    wake_cnt <= 4'(WAKE_HALT_CYCLES - 1);
                end
                else
                    wake_cnt <= wake_cnt - 4'h1;
            end
            ST_HALT:
            begin
                if (wake_cnt == 4'h0)
                    state <= ST_RUN;
                else
                    wake_cnt <= wake_cnt - 4'h1;
            end
            default:
                state <= ST_RUN;
        endcase
    end
end

assign core_halt = (state != ST_RUN) || internal_reset;

always_comb
begin
    clk_run = '{clk_cpu: 1'b1, clk_io: 1'b1, clk_conv: 1'b1,
        oscillator: 1'b1};
    if (state == ST_SLEEP || state == ST_WAKE)
    begin
        clk_run.clk_cpu = 1'b0;
        case (sleep_kind)
            NAP_IDLE: clk_run.clk_io = 1'b1;
            NAP_NOISE: clk_run.clk_io = 1'b0;
            NAP_POWER_DOWN:
            begin
                clk_run = '0;
            end
            default:
            begin
                clk_run.clk_io = 1'b0;
                clk_run.clk_conv = 1'b0;
            end
        endcase
    end
end

// wake logic stays powered outside this block
assign input_buffer_enable = clk_run.clk_io | clk_run.clk_conv;

////////////////////////////////////////////////////////////////////////////////
// peripheral clock gates

// gates freeze state rather than reset it
assign gate_stop = power_reduction;
assign comparator_enable = ~power_reduction[CONVERTER_GATE_BIT];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 4'h0;
        w_data <= 32'h0;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (aw_held && w_held)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == ADDR_SLEEP_CONTROL ||
                aw_addr == ADDR_POWER_REDUCTION || aw_addr == ADDR_STATUS)
            begin
                s_axi_bresp <= RESP_OKAY;
            end
            else
            begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// register writes
always_ff @(posedge aclk)
begin
    if (!aresetn || internal_reset)
    begin
        sleep_control <= SLEEP_CONTROL_RESET;
        power_reduction <= POWER_REDUCTION_RESET;
    end
    else if (aw_held && w_held && w_strb[0])
    begin
        if (aw_addr == ADDR_SLEEP_CONTROL)
        begin
            sleep_control <= w_data[7:0] & SLEEP_CONTROL_MASK;
        end
        else if (aw_addr == ADDR_POWER_REDUCTION)
        begin
            power_reduction <= w_data[7:0];
        end
    end
end

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr == ADDR_SLEEP_CONTROL)
            s_axi_rdata <= {24'h0, sleep_control};
        else if (s_axi_araddr == ADDR_POWER_REDUCTION)
            s_axi_rdata <= {24'h0, power_reduction};
        else if (s_axi_araddr == ADDR_STATUS)
        begin
            s_axi_rdata <= {24'h0, state, forced_continuous, brownout,
                wdog_pulse, internal_reset};
        end
        else
        begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
        end
    end
    else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

endmodule

// *** verif/spr_checker.sv ***
`timescale 1ns/1ps
module spr_checker
    import spr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sources and fuses
    input wire logic power_ok,
    input wire logic reset_pin_n,
    input wire logic reset_pin_enable,
    input wire logic wdog_expire,
    input wire logic wdog_enable,
    input wire logic [1:0] brownout_active_mode_fuse,
    // block outputs
    input wire logic core_halt,
    input wire logic core_restart,
    input wire logic port_reset,
    input wire logic internal_reset,
    input wire logic monitor_power,
    input wire spr_gates_t gate_stop,
    input wire spr_clk_run_t clk_run,
    input wire logic input_buffer_enable,
    input wire logic comparator_enable
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    a_source_port_reset:
        assert property ((!power_ok || reset_pin_enable && !reset_pin_n)
            |-> port_reset && internal_reset) else $error("source missed");
    a_power_drop_hold:
        assert property ($fell(power_ok) |-> internal_reset[*8])
            else $error("power reset short");
    a_pin_release_hold:
        assert property ($rose(reset_pin_n) && reset_pin_enable &&
            $stable(reset_pin_enable) |-> internal_reset[*8])
            else $error("pin release not stretched");
    a_wdog_pulse_reset:
        assert property ($rose(wdog_expire) && wdog_enable
            |-> ##[0:3] internal_reset) else $error("watchdog ignored");
    a_reset_halts_core:
        assert property (internal_reset |-> core_halt && core_restart)
            else $error("core runs in reset");
    a_reset_clears_gates:
        assert property (internal_reset |=> gate_stop == 8'h00)
            else $error("gates not cleared");
    a_buffers_off:
        assert property (input_buffer_enable ==
            (clk_run.clk_io || clk_run.clk_conv)) else $error("buffers");
    a_comparator_gated:
        assert property (gate_stop.converter |-> !comparator_enable)
            else $error("comparator on");
    a_monitor_active:
        assert property (!core_halt && (brownout_active_mode_fuse ==
            MON_ENABLED || brownout_active_mode_fuse == MON_RESERVED)
            |-> monitor_power) else $error("monitor off");
    c_release: cover property ($fell(internal_reset));
    c_sleeping: cover property (core_halt && !internal_reset);
    c_sampled: cover property ($rose(monitor_power) &&
        brownout_active_mode_fuse == MON_SAMPLED);
endmodule

// *** verif/spr_core_model.sv ***
`timescale 1ns/1ps
module spr_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench commands
    input wire logic do_sleep,
    input wire logic do_wake,
    // block side
    input wire logic core_halt,
    output logic sleep_exec = 1'b0,
    output logic wake_irq = 1'b0
);
    logic prev = 1'b0;
    // sleep instruction only issued while executing
    always_ff @(posedge aclk)
    begin
        prev <= do_sleep;
        sleep_exec <= aresetn && do_sleep && !prev && !core_halt;
    end
    always_ff @(posedge aclk)
        wake_irq <= aresetn && do_wake;
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb
    import spr_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic do_sleep = 1'b0, do_wake = 1'b0, sleep_exec, wake_irq;
    logic core_halt, core_restart, port_reset, internal_reset;
    logic monitor_power, input_buffer_enable, comparator_enable;
    logic power_ok = 1'b1, reset_pin_n = 1'b1, reset_pin_enable = 1'b1;
    logic wdog_expire = 1'b0, wdog_enable = 1'b1, undervoltage = 1'b0;
    logic [1:0] brownout_active_mode_fuse = 2'h2;
    logic [1:0] brownout_sleep_mode_fuse = 2'h3;
    spr_gates_t gate_stop;
    spr_clk_run_t clk_run;
    int err_count = 0, compares = 0, n, w;
    always #5 aclk = ~aclk;
    spr_sleep_power_reset_control #(
        .STARTUP_CYCLES(20),
        .SAMPLE_PERIOD(50)
    ) u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_exec, .wake_irq, .core_halt,
        .core_restart, .power_ok, .reset_pin_n, .reset_pin_enable,
        .wdog_expire, .wdog_enable, .undervoltage,
        .brownout_active_mode_fuse, .brownout_sleep_mode_fuse,
        .port_reset, .internal_reset, .monitor_power, .gate_stop,
        .clk_run, .input_buffer_enable, .comparator_enable
    );
    spr_core_model u_core (
        .aclk, .aresetn, .do_sleep, .do_wake, .core_halt, .sleep_exec,
        .wake_irq
    );
    ////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd_reg(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
    endtask
    task wait_release(input int exp, input string what);
        n = 0;
        while (internal_reset && n < 500)
        begin
            @(posedge aclk);
            n++;
        end
        check(n >= exp && n <= exp + 3, 1'b1, what);
    endtask
    ////////////////////////////////////////////////////////////
    task t_regs;
        rd_reg(ADDR_POWER_REDUCTION);
        check(rd, 32'h0, "pr reset");
        wr(ADDR_SLEEP_CONTROL, 32'hff);
        rd_reg(ADDR_SLEEP_CONTROL);
        check(rd, 32'h38, "sc read");
        rd_reg(4'hc);
        check(rsp, RESP_SLVERR, "unmapped");
    endtask
    task t_gates;
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_POWER_REDUCTION, 32'h1 << i);
            @(posedge aclk);
            check(gate_stop, 32'h1 << i, "gate");
            check(comparator_enable, i != 0, "comparator");
        end
        wr(ADDR_POWER_REDUCTION, 32'h0);
        @(posedge aclk);
        check(gate_stop, 32'h0, "gate clear");
    endtask
    task t_sleep(input logic arm, input logic [1:0] kind);
        wr(ADDR_SLEEP_CONTROL, {26'h0, arm, kind, 3'h0});
        do_sleep <= 1'b1;
        repeat (3) @(posedge aclk);
        do_sleep <= 1'b0;
        do_wake <= 1'b1;
        check(core_halt, arm, "halt");
        check(input_buffer_enable, !(arm && kind[1]), "buffers");
        w = (kind == NAP_STANDBY) ? STANDBY_WAKE_CYCLES : 1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (core_halt && n < 50);
        do_wake <= 1'b0;
        if (arm)
            check(n >= w + 5 && n <= w + 7, 1'b1, "wake");
    endtask
    task t_pin;
        wr(ADDR_POWER_REDUCTION, 32'hff);
        reset_pin_n <= 1'b0;
        #1;
        check({port_reset, internal_reset}, 2'h3, "pin");
        repeat (2) @(posedge aclk);
        check(gate_stop, 32'h0, "cleared");
        reset_pin_n <= 1'b1;
        wait_release(20, "pin stretch");
        reset_pin_enable <= 1'b0;
        reset_pin_n <= 1'b0;
        repeat (3) @(posedge aclk);
        check(internal_reset, 1'b0, "pin off");
        reset_pin_n <= 1'b1;
        @(posedge aclk);
        reset_pin_enable <= 1'b1;
    endtask
    task t_wdog(input logic en);
        wdog_enable <= en;
        wdog_expire <= 1'b1;
        @(posedge aclk);
        wdog_expire <= 1'b0;
        n = 0;
        while (!internal_reset && n < 6)
        begin
            @(posedge aclk);
            n++;
        end
        check(internal_reset, en, "wdog");
        if (en)
            wait_release(WDOG_PULSE_CYCLES + 19, "wdog stretch");
        wdog_enable <= 1'b1;
        @(posedge aclk);
    endtask
    task t_power;
        power_ok <= 1'b0;
        #1;
        check({port_reset, internal_reset}, 2'h3, "power");
        @(posedge aclk);
        power_ok <= 1'b1;
        wait_release(20, "power stretch");
    endtask
    task t_brown;
        undervoltage <= 1'b1;
        repeat (100) @(posedge aclk);
        check(internal_reset, 1'b0, "early bo");
        repeat (DETECT_CYCLES) @(posedge aclk);
        check(internal_reset, 1'b1, "bo");
        undervoltage <= 1'b0;
        wait_release(20, "bo stretch");
        brownout_active_mode_fuse <= MON_DISABLED;
        undervoltage <= 1'b1;
        repeat (300) @(posedge aclk);
        check(internal_reset, 1'b0, "bo off");
        brownout_active_mode_fuse <= MON_SAMPLED;
        repeat (300) @(posedge aclk);
        check(internal_reset, 1'b1, "sampled bo");
        undervoltage <= 1'b0;
        wait_release(20, "sampled stretch");
        n = 0;
        repeat (100)
        begin
            @(posedge aclk);
            n += monitor_power;
        end
        check(n > 0 && n < 50, 1'b1, "sampled");
        brownout_active_mode_fuse <= MON_ENABLED;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        err_count++;
        test_done;
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        while (internal_reset !== 1'b0)
            @(posedge aclk);
        t_regs;
        t_gates;
        t_sleep(1'b0, NAP_POWER_DOWN);
        for (int k = 0; k < 4; k++)
            t_sleep(1'b1, k[1:0]);
        t_pin;
        t_wdog(1'b1);
        t_wdog(1'b0);
        t_power;
        t_brown;
        test_done;
    end
endmodule
bind spr_sleep_power_reset_control spr_checker u_chk (
    .aclk, .aresetn, .power_ok, .reset_pin_n, .reset_pin_enable,
    .wdog_expire, .wdog_enable, .brownout_active_mode_fuse, .core_halt,
    .core_restart, .port_reset, .internal_reset, .monitor_power,
    .gate_stop, .clk_run, .input_buffer_enable, .comparator_enable
);
